// *** src/pbrc_pkg.sv ***
// package for the push-button power and reset controller pair
// assumes a single 200 MHz clock shared by both ends
package pbrc_pkg;

  // clock and timebase
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1000000; // one millisecond timebase
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 18;

  // press, reset and watchdog times in milliseconds
  localparam int PWRON_PRESS_MS = 32;
  localparam int FORCE_OFF_MS = 10000;
  localparam int LONG_PRESS_MS = 4000;
  localparam int RESET_TIMEOUT_MS = 20;
  localparam int WDOG_MS = 4000;
  localparam int SWPC_DELAY_MS = 8;
  localparam int CYCLE_OFF_MS = 10;
  localparam int MS_W = 14;
  typedef logic [MS_W-1:0] pbrc_ms_type;
  localparam pbrc_ms_type MS_ZERO = 14'h0000;
  localparam pbrc_ms_type MS_ONE = 14'h0001;
  localparam pbrc_ms_type MS_MAX = 14'h3FFF;

  // device register link
  localparam int DADDR_W = 4;
  localparam int DDATA_W = 8;
  localparam logic [3:0] DEV_SYSCTL = 4'h0;
  localparam logic [3:0] DEV_STATUS = 4'h1;
  localparam logic [3:0] DEV_IRQMASK = 4'h2;
  localparam logic [3:0] DEV_LDOOFF = 4'h3;
  localparam int SC_SHUTDOWN_REQ = 0;
  localparam int SC_ARM_CLEAR = 1;
  localparam int SC_SWPC_REQ = 2;
  localparam int SC_WD_SR_EN = 3;
  localparam int SC_WD_PC_EN = 4;
  localparam int ST_SOFT_RESET = 0;
  localparam int ST_POWER_CYCLE = 1;
  localparam int ST_BUTTON = 2;
  localparam int IRQ_N = 3;
  localparam int LDO_N = 6;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // regulator sets, bit k drives regulator k+1
  localparam int REG_N = 13;
  localparam logic [12:0] REGS_NONE = 13'h0000;
  localparam logic [12:0] REGS_ALL = 13'h1FFF;
  localparam logic [12:0] REGS_ALWAYS_ON = 13'h1000;
  localparam logic [12:0] REGS_SLEEP = 13'h141B;
  localparam logic [12:0] REGS_CORE = 13'h0004;
  localparam logic [12:0] REGS_LDO_SW = 13'h0BE0;

  // host apb map
  localparam int PADDR_W = 12;
  localparam logic [11:0] HOST_CTRL = 12'h000;
  localparam logic [11:0] HOST_CMD = 12'h004;
  localparam logic [11:0] HOST_STAT = 12'h008;
  localparam int HC_HOLD = 0;
  localparam int HC_GROUP = 1;
  localparam int CMD_WDATA_LSB = 8;
  localparam int CMD_WRITE = 16;
  localparam int HS_BUTTON = 0;
  localparam int HS_IRQ = 1;
  localparam int HS_RESET = 2;
  localparam int HS_RDATA_LSB = 8;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [4:0] {
    DS_OFF = 5'h01,
    DS_BOOT = 5'h02,
    DS_ON = 5'h04,
    DS_SLEEP = 5'h08,
    DS_CYCLE = 5'h10
  } pbrc_dev_state_type;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_LINK = 3'h2,
    HS_DONE = 3'h4
  } pbrc_host_state_type;

endpackage

// *** src/pbrc_if.sv ***
// pins between the power controller and the host processor
// assumes both ends run on the same clock; open-drain lines pulled high
`timescale 1ns/1ps
interface pbrc_if;
  import pbrc_pkg::*;
  // processor-driven level inputs of the controller
  logic power_hold;
  logic regulator_group_enable;
  // open-drain outputs: value, enable, and the pulled-up line level
  logic button_status_out_n_o;
  logic button_status_out_n_oe;
  logic system_reset_out_n_o;
  logic system_reset_out_n_oe;
  logic interrupt_out_n_o;
  logic interrupt_out_n_oe;
  logic button_status_line_n;
  logic system_reset_line_n;
  logic interrupt_line_n;
  // register link standing in for the serial control bus
  logic reg_req;
  logic reg_we;
  logic [DADDR_W-1:0] reg_addr;
  logic [DDATA_W-1:0] reg_wdata;
  logic reg_ack;
  logic [DDATA_W-1:0] reg_rdata;

  // a line reads low only while its driver enables a low output
  assign button_status_line_n =
    ~(button_status_out_n_oe & ~button_status_out_n_o);
  assign system_reset_line_n =
    ~(system_reset_out_n_oe & ~system_reset_out_n_o);
  assign interrupt_line_n = ~(interrupt_out_n_oe & ~interrupt_out_n_o);

  modport device (
    input power_hold, regulator_group_enable, reg_req, reg_we, reg_addr,
    input reg_wdata,
    output button_status_out_n_o, button_status_out_n_oe,
    output system_reset_out_n_o, system_reset_out_n_oe,
    output interrupt_out_n_o, interrupt_out_n_oe, reg_ack, reg_rdata
  );
  modport host (
    output power_hold, regulator_group_enable, reg_req, reg_we, reg_addr,
    output reg_wdata,
    input button_status_line_n, system_reset_line_n, interrupt_line_n,
    input reg_ack, reg_rdata
  );
endinterface

// *** src/pbrc_device.sv ***
// power controller end: button, reset, sleep, watchdog and power cycle
// assumes inputs synchronous to CLOCK and a debounced push-button
//
// Behaviour
// - power on after 32 ms resistor press
// - no power hold at release aborts boot
// - stay on while power hold high
// - processor may delay power hold for longer press
// - shutdown by arm-then-request or hold low
// - 10 s resistor press forces shutdown; a direct press never does
// - short direct press: reset until release plus timeout
// - soft reset sets flag, cleared on read
// - software pulses watchdog soft reset after reset
// - long direct press power cycles regulators
// - power cycle sets flag, cleared on read
// - button status low while button pressed
// - reset low at startup until timeout
// - interrupt low while any unmasked source active
// - interrupt sources masked after reset
// - processor turns off LDOs then group enable
// - sleep keeps regulators 1,2,4,5,11 on
// - button or group enable wakes from sleep
// - 4 s watchdog runs only when enabled
// - any register access restarts watchdog
// - watchdog expiry soft resets or power cycles
// - power cycle request waits 8 ms first
// - hold and enable high keep all on
`timescale 1ns/1ps
module pbrc_device import pbrc_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int PWRON_MS = PWRON_PRESS_MS,
  parameter int FORCE_MS = FORCE_OFF_MS,
  parameter int LONG_MS = LONG_PRESS_MS,
  parameter int RESET_MS = RESET_TIMEOUT_MS,
  parameter int WD_MS = WDOG_MS,
  parameter int SWPC_MS = SWPC_DELAY_MS,
  parameter int OFF_MS = CYCLE_OFF_MS
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // push-button, low while pressed; DIRECT marks a low-impedance press
  input wire logic PUSHBUTTON_IN_N,
  input wire logic PUSHBUTTON_DIRECT,
  // regulator enables, bit k for regulator k+1
  output logic [REG_N-1:0] REG_EN,
  // pins towards the processor
  pbrc_if.device LINK
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // threshold reached on a millisecond count
  function automatic logic ms_reached(pbrc_ms_type cnt, int lim);
    ms_reached = cnt >= MS_W'(lim);
  endfunction

  // expand the six switchable LDO bits to their regulator positions
  function automatic logic [REG_N-1:0] ldo_map(logic [LDO_N-1:0] off);
    ldo_map = {1'b0, off[5], 1'b0, off[4:0], 5'b00000};
  endfunction

  pbrc_dev_state_type state_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick_reg;
  pbrc_ms_type press_ms_reg, rst_ms_reg, wd_ms_reg, swpc_ms_reg, off_ms_reg;
  logic pressed_prev_reg, direct_seen_reg, press_used_reg;
  logic rst_run_reg, group_prev_reg;
  logic arm_reg, wd_sr_en_reg, wd_pc_en_reg, swpc_pend_reg;
  logic soft_flag_reg, pc_flag_reg;
  logic [IRQ_N-1:0] irq_unmask_reg;
  logic [LDO_N-1:0] ldo_off_reg;
  logic ack_reg;
  logic [DDATA_W-1:0] rdata_reg;
  logic [REG_N-1:0] reg_en_reg;
  logic btn_oe_reg, rst_oe_reg, irq_oe_reg;

  logic pressed, released, access, wr, rd, on_like;
  logic pwr_on, force_off, mr_long, mr_short, wd_expire, swpc_fire;
  logic shutdown_sw, hold_lost, soft_reset, go_cycle;
  logic [DDATA_W-1:0] rd_value;
  logic [IRQ_N-1:0] irq_src;

  assign pressed = ~PUSHBUTTON_IN_N;
  assign released = pressed_prev_reg & ~pressed;
  assign access = LINK.reg_req & ~ack_reg;
  assign wr = access & LINK.reg_we;
  assign rd = access & ~LINK.reg_we;
  assign on_like = (state_reg == DS_ON) | (state_reg == DS_SLEEP);

  // press events
  assign pwr_on = (state_reg == DS_OFF) & pressed & ~direct_seen_reg &
    ms_reached(press_ms_reg, PWRON_MS);
  assign force_off = (on_like | (state_reg == DS_BOOT)) & pressed &
    ~direct_seen_reg & ms_reached(press_ms_reg, FORCE_MS);
  assign mr_long = on_like & pressed & direct_seen_reg & ~press_used_reg &
    ms_reached(press_ms_reg, LONG_MS);
  assign mr_short = on_like & released & direct_seen_reg &
    ~press_used_reg & ~ms_reached(press_ms_reg, LONG_MS);
  // watchdog and software requests
  assign wd_expire = on_like & (wd_sr_en_reg | wd_pc_en_reg) & tick_reg &
    ms_reached(wd_ms_reg + MS_ONE, WD_MS);
  assign swpc_fire = swpc_pend_reg & tick_reg &
    ms_reached(swpc_ms_reg + MS_ONE, SWPC_MS);
  assign shutdown_sw = wr & (LINK.reg_addr == DEV_SYSCTL) & arm_reg &
    LINK.reg_wdata[SC_SHUTDOWN_REQ];
  // hold is judged only once the processor is out of reset
  assign hold_lost = on_like & ~rst_run_reg & ~LINK.power_hold;
  assign soft_reset = mr_short | (wd_expire & wd_sr_en_reg);
  assign go_cycle = mr_long | swpc_fire |
    (wd_expire & ~wd_sr_en_reg);

  // millisecond enable from the clock divider
  always_ff @(posedge CLOCK) begin
    if (!RESET_N | (tick_cnt_reg == TICK_LAST)) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
    tick_reg <= RESET_N & (tick_cnt_reg == TICK_LAST);
  end

  // press duration and kind, kept until release
  always_ff @(posedge CLOCK) begin
    if (!RESET_N | !pressed) begin
      press_ms_reg <= MS_ZERO;
      direct_seen_reg <= 1'b0;
    end else begin
      if (tick_reg && press_ms_reg != MS_MAX) begin
        press_ms_reg <= press_ms_reg + MS_ONE;
      end
      if (PUSHBUTTON_DIRECT) begin
        direct_seen_reg <= 1'b1;
      end
    end
    pressed_prev_reg <= RESET_N & pressed;
    // one long action per press
    if (!RESET_N | !pressed) begin
      press_used_reg <= 1'b0;
    end else if (mr_long) begin
      press_used_reg <= 1'b1;
    end
  end

  // power state machine
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_reg <= DS_OFF;
    end else if (force_off | shutdown_sw | hold_lost) begin
      state_reg <= DS_OFF;
    end else if (go_cycle) begin
      state_reg <= DS_CYCLE;
    end else begin
      case (state_reg)
        DS_OFF: if (pwr_on) state_reg <= DS_BOOT;
        DS_BOOT: begin
          if (released) begin
            state_reg <= LINK.power_hold ? DS_ON : DS_OFF;
          end
        end
        DS_ON: begin
          if (group_prev_reg & ~LINK.regulator_group_enable) begin
            state_reg <= DS_SLEEP;
          end
        end
        DS_SLEEP: begin
          if (pressed | LINK.regulator_group_enable) begin
            state_reg <= DS_ON;
          end
        end
        DS_CYCLE: begin
          if (tick_reg && ms_reached(off_ms_reg + MS_ONE, OFF_MS)) begin
            state_reg <= DS_ON;
          end
        end
        default: state_reg <= DS_OFF;
      endcase
    end
    group_prev_reg <= RESET_N & LINK.regulator_group_enable;
  end

  // off time of a power cycle
  always_ff @(posedge CLOCK) begin
    if (!RESET_N | (state_reg != DS_CYCLE)) begin
      off_ms_reg <= MS_ZERO;
    end else if (tick_reg) begin
      off_ms_reg <= off_ms_reg + MS_ONE;
    end
  end

  // reset time-out: restarts at boot, after a cycle and on soft reset;
  // a direct press holds it at zero so the wait begins at release
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      rst_run_reg <= 1'b0;
      rst_ms_reg <= MS_ZERO;
    end else if (pwr_on | soft_reset | (state_reg == DS_CYCLE) |
                 (on_like & pressed & direct_seen_reg)) begin
      rst_run_reg <= 1'b1;
      rst_ms_reg <= MS_ZERO;
    end else if (rst_run_reg & tick_reg) begin
      rst_ms_reg <= rst_ms_reg + MS_ONE;
      if (ms_reached(rst_ms_reg + MS_ONE, RESET_MS)) begin
        rst_run_reg <= 1'b0;
      end
    end
  end

  // watchdog restarted by every register access
  always_ff @(posedge CLOCK) begin
    if (!RESET_N | access | wd_expire | !on_like |
        !(wd_sr_en_reg | wd_pc_en_reg)) begin
      wd_ms_reg <= MS_ZERO;
    end else if (tick_reg) begin
      wd_ms_reg <= wd_ms_reg + MS_ONE;
    end
  end

  // software power-cycle delay
  always_ff @(posedge CLOCK) begin
    if (!RESET_N | swpc_fire) begin
      swpc_pend_reg <= 1'b0;
      swpc_ms_reg <= MS_ZERO;
    end else if (wr && LINK.reg_addr == DEV_SYSCTL &&
                 LINK.reg_wdata[SC_SWPC_REQ]) begin
      swpc_pend_reg <= 1'b1;
      swpc_ms_reg <= MS_ZERO;
    end else if (swpc_pend_reg & tick_reg) begin
      swpc_ms_reg <= swpc_ms_reg + MS_ONE;
    end
  end

  // control registers written over the link
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      arm_reg <= 1'b0;
      wd_sr_en_reg <= 1'b0;
      wd_pc_en_reg <= 1'b0;
      irq_unmask_reg <= '0;
      ldo_off_reg <= '0;
    end else if (wr) begin
      if (LINK.reg_addr == DEV_SYSCTL) begin
        // the arm bit is consumed by the shutdown it enables
        arm_reg <= LINK.reg_wdata[SC_ARM_CLEAR] & ~shutdown_sw;
        wd_sr_en_reg <= LINK.reg_wdata[SC_WD_SR_EN];
        wd_pc_en_reg <= LINK.reg_wdata[SC_WD_PC_EN];
      end else if (LINK.reg_addr == DEV_IRQMASK) begin
        irq_unmask_reg <= LINK.reg_wdata[IRQ_N-1:0];
      end else if (LINK.reg_addr == DEV_LDOOFF) begin
        ldo_off_reg <= LINK.reg_wdata[LDO_N-1:0];
      end
    end
  end

  // sticky flags; a new event wins over the clearing read
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      soft_flag_reg <= 1'b0;
      pc_flag_reg <= 1'b0;
    end else begin
      soft_flag_reg <= soft_reset |
        (soft_flag_reg & ~(rd && LINK.reg_addr == DEV_STATUS));
      pc_flag_reg <= (state_reg == DS_CYCLE && state_reg != DS_OFF &&
        tick_reg && ms_reached(off_ms_reg + MS_ONE, OFF_MS)) |
        (pc_flag_reg & ~(rd && LINK.reg_addr == DEV_STATUS));
    end
  end

  // read mux
  always_comb begin
    rd_value = BYTE_ZERO;
    if (LINK.reg_addr == DEV_SYSCTL) begin
      rd_value[SC_ARM_CLEAR] = arm_reg;
      rd_value[SC_SWPC_REQ] = swpc_pend_reg;
      rd_value[SC_WD_SR_EN] = wd_sr_en_reg;
      rd_value[SC_WD_PC_EN] = wd_pc_en_reg;
    end else if (LINK.reg_addr == DEV_STATUS) begin
      rd_value[ST_SOFT_RESET] = soft_flag_reg;
      rd_value[ST_POWER_CYCLE] = pc_flag_reg;
      rd_value[ST_BUTTON] = pressed;
    end else if (LINK.reg_addr == DEV_IRQMASK) begin
      rd_value[IRQ_N-1:0] = irq_unmask_reg;
    end else if (LINK.reg_addr == DEV_LDOOFF) begin
      rd_value[LDO_N-1:0] = ldo_off_reg;
    end
  end

  // link answer: one cycle after the request, held one cycle
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ack_reg <= 1'b0;
      rdata_reg <= BYTE_ZERO;
    end else begin
      ack_reg <= access;
      if (rd) begin
        rdata_reg <= rd_value;
      end
    end
  end

  assign irq_src = {pc_flag_reg, soft_flag_reg, pressed};

  // regulator enables and open-drain pins, all registered
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      reg_en_reg <= REGS_NONE;
      btn_oe_reg <= 1'b0;
      rst_oe_reg <= 1'b1;
      irq_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        DS_BOOT: reg_en_reg <= REGS_ALL;
        // the core rail stays up in ON, so a button wake keeps it after
        // release; the sleep, cycle and off states park it
        DS_ON: reg_en_reg <= (REGS_ALL & ~ldo_map(ldo_off_reg)) |
          REGS_CORE;
        DS_SLEEP: reg_en_reg <= REGS_SLEEP;
        default: reg_en_reg <= REGS_ALWAYS_ON;
      endcase
      btn_oe_reg <= pressed;
      rst_oe_reg <= ~on_like | rst_run_reg |
        (pressed & PUSHBUTTON_DIRECT);
      irq_oe_reg <= |(irq_src & irq_unmask_reg);
    end
  end

  assign REG_EN = reg_en_reg;
  assign LINK.button_status_out_n_o = 1'b0;
  assign LINK.button_status_out_n_oe = btn_oe_reg;
  assign LINK.system_reset_out_n_o = 1'b0;
  assign LINK.system_reset_out_n_oe = rst_oe_reg;
  assign LINK.interrupt_out_n_o = 1'b0;
  assign LINK.interrupt_out_n_oe = irq_oe_reg;
  assign LINK.reg_ack = ack_reg;
  assign LINK.reg_rdata = rdata_reg;

endmodule

// *** src/pbrc_host.sv ***
// processor end: drives hold and group enable, runs register accesses
// assumes software on an apb bus in the same clock domain
`timescale 1ns/1ps
module pbrc_host import pbrc_pkg::*; (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [PADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pins towards the power controller
  pbrc_if.host LINK
);

  pbrc_host_state_type state_reg;
  logic hold_reg, group_reg;
  logic req_reg, we_reg;
  logic [DADDR_W-1:0] addr_reg;
  logic [DDATA_W-1:0] wdata_reg, rbyte_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic acc, is_ctrl, is_cmd, is_stat;
  logic [31:0] stat_word;

  assign acc = PSEL & PENABLE & ~pready_reg;
  assign is_ctrl = PADDR == HOST_CTRL;
  assign is_cmd = PADDR == HOST_CMD;
  assign is_stat = PADDR == HOST_STAT;

  always_comb begin
    stat_word = WORD_ZERO;
    stat_word[HS_BUTTON] = ~LINK.button_status_line_n;
    stat_word[HS_IRQ] = ~LINK.interrupt_line_n;
    stat_word[HS_RESET] = ~LINK.system_reset_line_n;
    stat_word[HS_RDATA_LSB +: DDATA_W] = rbyte_reg;
  end

  // apb access; a command write stalls until the link answers
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_reg <= HS_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= WORD_ZERO;
      hold_reg <= 1'b0;
      group_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= BYTE_ZERO;
      rbyte_reg <= BYTE_ZERO;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      case (state_reg)
        HS_IDLE: begin
          if (acc && is_cmd && PWRITE) begin
            req_reg <= 1'b1;
            we_reg <= PWDATA[CMD_WRITE];
            addr_reg <= PWDATA[DADDR_W-1:0];
            wdata_reg <= PWDATA[CMD_WDATA_LSB +: DDATA_W];
            state_reg <= HS_LINK;
          end else if (acc) begin
            pready_reg <= 1'b1;
            pslverr_reg <= ~(is_ctrl | is_cmd | is_stat);
            prdata_reg <= WORD_ZERO;
            if (PWRITE && is_ctrl) begin
              hold_reg <= PWDATA[HC_HOLD];
              group_reg <= PWDATA[HC_GROUP];
            end else if (!PWRITE && is_ctrl) begin
              prdata_reg[HC_HOLD] <= hold_reg;
              prdata_reg[HC_GROUP] <= group_reg;
            end else if (!PWRITE && is_stat) begin
              prdata_reg <= stat_word;
            end
          end
        end
        HS_LINK: begin
          if (LINK.reg_ack) begin
            req_reg <= 1'b0;
            if (!we_reg) begin
              rbyte_reg <= LINK.reg_rdata;
            end
            state_reg <= HS_DONE;
          end
        end
        HS_DONE: begin
          pready_reg <= 1'b1;
          state_reg <= HS_IDLE;
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign LINK.power_hold = hold_reg;
  assign LINK.regulator_group_enable = group_reg;
  assign LINK.reg_req = req_reg;
  assign LINK.reg_we = we_reg;
  assign LINK.reg_addr = addr_reg;
  assign LINK.reg_wdata = wdata_reg;

endmodule

// *** testbench/pbrc_link_asserts.sv ***
// checker for the pin and register link between the two ends
// assumes it sits beside the interface in the bench top, one clock
`timescale 1ns/1ps
module pbrc_link_asserts import pbrc_pkg::*; (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // register link
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [3:0] reg_addr,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  // open-drain pins
  input wire logic system_reset_line_n,
  input wire logic interrupt_line_n
);
  default clocking cb_main @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // link answers exactly one cycle after the request is taken
  property p_ack_answer; $rose(reg_req) |=> reg_ack; endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("link ack late");
  property p_ack_pulse; reg_ack |=> !reg_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("link ack too long");
  property p_ack_cause; reg_ack |-> $past(reg_req); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  // host keeps the request steady until it is answered
  property p_req_hold;
    reg_req && !reg_ack |=> reg_req && $stable(reg_addr) && $stable(reg_we);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before ack");
  property p_rdata_moves; $changed(reg_rdata) |-> reg_ack; endproperty
  a_rdata_moves: assert property (p_rdata_moves)
    else $error("read data moved without ack");
  // interrupt line stays released until software writes the mask
  logic mask_seen;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      mask_seen <= 1'b0;
    end else if (reg_ack && reg_we && reg_addr == DEV_IRQMASK) begin
      mask_seen <= 1'b1;
    end
  end
  property p_irq_gated; !mask_seen |-> interrupt_line_n; endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt active while masked");
  property p_reset_boot;
    $rose(RESET_N) |-> !system_reset_line_n [*3];
  endproperty
  a_reset_boot: assert property (p_reset_boot)
    else $error("reset line not low at startup");
  property p_irq_masked; $rose(RESET_N) |-> interrupt_line_n [*4]; endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt active out of reset");
endmodule

// *** testbench/pbrc_tb_top.sv ***
// bench joining controller and processor ends, driven over apb
// assumes a scaled millisecond tick of four clock cycles
`timescale 1ns/1ps
module pbrc_tb_top;
  import pbrc_pkg::*;
  localparam int TK = 4;
  logic clock, reset_n, pb_n, pb_direct, psel, penable, pwrite, pready, er;
  logic pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] reg_en;
  logic [7:0] by;
  int err_total, checked;

  // short times keep the run brief; all expectations scale with them
  pbrc_if link();
  pbrc_device #(.TICK_CYC(TK), .PWRON_MS(2), .FORCE_MS(40), .LONG_MS(8),
    .RESET_MS(3), .WD_MS(60), .SWPC_MS(2), .OFF_MS(2)) u_pbrc_device (
    .CLOCK(clock), .RESET_N(reset_n), .PUSHBUTTON_IN_N(pb_n),
    .PUSHBUTTON_DIRECT(pb_direct), .REG_EN(reg_en), .LINK(link));
  pbrc_host u_pbrc_host (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  pbrc_link_asserts u_pbrc_link_asserts (.CLOCK(clock), .RESET_N(reset_n),
    .reg_req(link.reg_req), .reg_we(link.reg_we), .reg_addr(link.reg_addr),
    .reg_ack(link.reg_ack), .reg_rdata(link.reg_rdata),
    .system_reset_line_n(link.system_reset_line_n),
    .interrupt_line_n(link.interrupt_line_n));

  // clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one apb transfer; the wait is bounded so a dead slave ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      give_verdict();
    end
  endtask
  // device register access through the host command word
  task automatic dev(input logic w, input logic [3:0] a, input logic [7:0] d);
    apb(1'b1, HOST_CMD, {15'h0000, w, d, 4'h0, a});
    if (!w) begin
      apb(1'b0, HOST_STAT, WORD_ZERO);
      by = rd[15:8];
    end
  endtask
  task automatic wait_en(input logic [12:0] v);
    int n;
    n = 0;
    while (reg_en !== v && n < 250) begin
      @(posedge clock);
      n++;
    end
    if (n >= 250) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic s_power_on();
    pb_n <= 1'b0;
    cyc(2);
    pb_n <= 1'b1;
    cyc(4);
    chk("short press", 32'(reg_en), 32'(REGS_ALWAYS_ON));
    pb_n <= 1'b0;
    cyc(6 * TK);
    chk("boot rails", 32'(reg_en), 32'(REGS_ALL));
    chk("boot reset", 32'(link.system_reset_line_n), 32'h0);
    chk("btn line", 32'(link.button_status_line_n), 32'h0);
    pb_n <= 1'b1;
    cyc(10);
    chk("no hold", 32'(reg_en), 32'(REGS_ALWAYS_ON));
    apb(1'b1, HOST_CTRL, 32'h0000_0003);
    pb_n <= 1'b0;
    cyc(6 * TK);
    pb_n <= 1'b1;
    cyc(8 * TK);
    chk("held on", 32'(reg_en), 32'(REGS_ALL));
    chk("reset out", 32'(link.system_reset_line_n), 32'h1);
  endtask
  task automatic s_sleep();
    apb(1'b1, HOST_CTRL, 32'h0000_0001);
    cyc(10);
    chk("sleep rails", 32'(reg_en), 32'(REGS_SLEEP));
    pb_n <= 1'b0;
    cyc(6);
    pb_n <= 1'b1;
    cyc(6);
    chk("button wake", 32'(reg_en[2]), 32'h1);
    apb(1'b1, HOST_CTRL, 32'h0000_0003);
    apb(1'b1, HOST_CTRL, 32'h0000_0001);
    cyc(10);
    apb(1'b1, HOST_CTRL, 32'h0000_0003);
    cyc(10);
    chk("group wake", 32'(reg_en), 32'(REGS_ALL));
  endtask
  task automatic s_irq();
    dev(1'b0, DEV_IRQMASK, BYTE_ZERO);
    chk("mask reset", 32'(by), 32'h0);
    dev(1'b0, 4'hF, BYTE_ZERO);
    chk("unmapped dev", 32'(by), 32'h0);
    apb(1'b0, 12'h010, WORD_ZERO);
    chk("unmapped apb", 32'(er), 32'h1);
    dev(1'b1, DEV_IRQMASK, 8'h01);
    pb_n <= 1'b0;
    cyc(6);
    chk("irq line", 32'(link.interrupt_line_n), 32'h0);
    pb_n <= 1'b1;
    cyc(6);
    chk("btn released", 32'(link.button_status_line_n), 32'h1);
  endtask
  task automatic s_soft();
    pb_direct <= 1'b1;
    pb_n <= 1'b0;
    cyc(3);
    chk("reset at once", 32'(link.system_reset_line_n), 32'h0);
    cyc(2 * TK);
    pb_n <= 1'b1;
    pb_direct <= 1'b0;
    cyc(2);
    chk("reset past release", 32'(link.system_reset_line_n), 32'h0);
    cyc(6 * TK);
    dev(1'b0, DEV_STATUS, BYTE_ZERO);
    chk("soft flag", 32'(by), 32'h1);
    dev(1'b0, DEV_STATUS, BYTE_ZERO);
    chk("soft flag read", 32'(by), 32'h0);
    // watchdog soft reset armed, left to expire, then cleared again
    dev(1'b1, DEV_SYSCTL, 8'h08);
    cyc(70 * TK);
    dev(1'b0, DEV_STATUS, BYTE_ZERO);
    chk("watchdog soft", 32'(by), 32'h1);
    dev(1'b1, DEV_SYSCTL, BYTE_ZERO);
  endtask
  // power cycle from a long direct press or from the software request
  task automatic s_cycle(input logic sw);
    if (sw) dev(1'b1, DEV_SYSCTL, 8'h04);
    else begin
      pb_direct <= 1'b1;
      pb_n <= 1'b0;
      cyc(6 * TK);
    end
    chk("before cycle", 32'(reg_en), 32'(REGS_ALL));
    wait_en(REGS_ALWAYS_ON);
    pb_n <= 1'b1;
    pb_direct <= 1'b0;
    cyc(12 * TK);
    chk("after cycle", 32'(reg_en), 32'(REGS_ALL));
    dev(1'b0, DEV_STATUS, BYTE_ZERO);
    chk("cycle flag", 32'(by), 32'h2);
  endtask
  task automatic s_off();
    dev(1'b1, DEV_SYSCTL, 8'h02);
    dev(1'b1, DEV_SYSCTL, 8'h03);
    cyc(10);
    chk("shutdown", 32'(reg_en), 32'(REGS_ALWAYS_ON));
    // drop hold so the next boot sees no hold at release
    apb(1'b1, HOST_CTRL, WORD_ZERO);
    s_power_on();
    pb_n <= 1'b0;
    cyc(30 * TK);
    chk("not forced yet", 32'(reg_en), 32'(REGS_ALL));
    wait_en(REGS_ALWAYS_ON);
    pb_n <= 1'b1;
  endtask

  // main sequence
  initial begin
    {reset_n, pb_direct, psel, penable, pwrite} = 5'h00;
    pb_n = 1'b1;
    paddr = 12'h000;
    pwdata = WORD_ZERO;
    err_total = 0;
    checked = 0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(2);
    s_power_on();
    s_sleep();
    s_irq();
    s_soft();
    s_cycle(1'b1);
    s_cycle(1'b0);
    s_off();
    give_verdict();
  end
endmodule
